//--- rspf_pkg.sv
// Operation
// - sample oscillator strap at reset rise, hold
// - strap low selects pierce/external clock
// - strap high selects colpitts oscillator
// - floating oscillator strap pulled up, colpitts
// - debug pin captured into high mode bit
// - mid strap pin captured into mid bit
// - mid strap pull-down only during reset
// - in expanded modes, tag-high low at bus clock fall tags high
// - fast debug port single-wire by default
// - link select high gives spi mode
// - spi mode clock comes from link select pin
// - serial out drives low in and after reset
// - free-cycle indicator marks unused bus cycles in expanded modes
// - reset pin bidirectional, internal reset drives low
// - expanded modes: ports a/b carry address/data
// - narrow modes multiplex data bytes on port a
// - low strap pin captured into low bit
`default_nettype none
package rspf_pkg;
  localparam logic rst_osc_type = 1'b1;
  localparam logic [2:0] rst_mode = 3'h0;
  // low bit of the mode code marks an expanded mode, bit 1 a wide bus
  localparam int mode_exp_bit = 0;
  localparam int mode_wide_bit = 1;
  localparam logic [7:0] rst_port = 8'h00;
  // cycles the serial output stays low after reset release
  localparam int so_hold_cycles = 2;
endpackage : rspf_pkg
`default_nettype wire

//--- rspf_top.sv
`timescale 1ns/10ps
`default_nettype none
module rspf_top #(
  parameter int port_w = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // reset pin, active low, bidirectional
  input wire logic reset_pin_n_i,
  input wire logic int_reset_req_i,
  output logic reset_pin_n_o,
  output logic reset_pin_oe_o,
  // straps
  input wire logic osc_type_strap_i,
  input wire logic osc_type_strap_float_i,
  input wire logic debug_strap_pin_i,
  input wire logic mode_select_mid_i,
  input wire logic mode_select_low_i,
  output logic mode_select_mid_pd_en_o,
  output logic osc_colpitts_o,
  output logic osc_pierce_o,
  output logic [2:0] mode_o,
  // debug port
  input wire logic debug_link_select_i,
  input wire logic debug_sdo_i,
  output logic debug_spi_mode_o,
  output logic debug_serial_clock_o,
  output logic debug_so_o,
  // bus cycle control
  input wire logic bus_clock_out_i,
  input wire logic tag_enable_i,
  input wire logic tag_high_input_i,
  input wire logic free_cycle_en_i,
  input wire logic cpu_bus_idle_i,
  output logic tag_high_o,
  output logic free_cycle_indicator_o,
  // ports a/b
  input wire logic [port_w-1:0] addr_hi_i,
  input wire logic [port_w-1:0] addr_lo_i,
  input wire logic [port_w-1:0] data_hi_i,
  input wire logic [port_w-1:0] data_lo_i,
  input wire logic addr_phase_i,
  input wire logic narrow_hi_phase_i,
  input wire logic bus_write_i,
  input wire logic [port_w-1:0] gpio_a_i,
  input wire logic [port_w-1:0] gpio_b_i,
  input wire logic [port_w-1:0] gpio_a_oe_i,
  input wire logic [port_w-1:0] gpio_b_oe_i,
  output logic [port_w-1:0] port_a_o,
  output logic [port_w-1:0] port_b_o,
  output logic [port_w-1:0] port_a_oe_o,
  output logic [port_w-1:0] port_b_oe_o
);
  logic in_reset;
  logic rst_rise;
  logic rst_seen_q;
  logic osc_strap;
  logic osc_q;
  logic [2:0] mode_q;
  logic [1:0] so_cnt_q;
  logic bus_clock_out_prev_q;
  logic bus_clock_out_fall;
  logic expanded;
  logic wide;
  logic [port_w-1:0] a_bus_val;
  logic [port_w-1:0] b_bus_val;
  logic [port_w-1:0] a_val;
  logic [port_w-1:0] b_val;
  logic [port_w-1:0] a_oe;
  logic [port_w-1:0] b_oe;

  // internal reset also pulls the shared pin low
  assign in_reset = ~reset_pin_n_i | int_reset_req_i;
  assign rst_rise = rst_seen_q & ~in_reset;
  assign osc_strap = osc_type_strap_float_i ? 1'b1 : osc_type_strap_i;
  assign bus_clock_out_fall = bus_clock_out_prev_q & ~bus_clock_out_i;
  assign expanded = mode_q[rspf_pkg::mode_exp_bit];
  assign wide = mode_q[rspf_pkg::mode_wide_bit];
  // address phase drives both bytes; narrow data phase muxes hi/lo bytes on port a
  assign a_bus_val = addr_phase_i ? addr_hi_i :
                     (!wide && !narrow_hi_phase_i) ? data_lo_i : data_hi_i;
  assign b_bus_val = addr_phase_i ? addr_lo_i : data_lo_i;

  // one mux slice per pad, so a wider port only changes port_w
  for (genvar i = 0; i < port_w; i++)
  begin : g_pad
    assign a_val[i] = expanded ? a_bus_val[i] : gpio_a_i[i];
    assign b_val[i] = expanded ? b_bus_val[i] : gpio_b_i[i];
    assign a_oe[i] = expanded ? (addr_phase_i | bus_write_i) : gpio_a_oe_i[i];
    // narrow mode leaves port b to address only
    assign b_oe[i] = expanded ? (addr_phase_i | (bus_write_i & wide)) : gpio_b_oe_i[i];
  end

  // remembers that the last cycle was still in reset, to find the release edge
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_seen_q <= 1'b1;
    end
    else
    begin
      rst_seen_q <= in_reset;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_q <= rspf_pkg::rst_osc_type;
      mode_q <= rspf_pkg::rst_mode;
    end
    else
    begin
      // straps only move on reset release, then stay put
      if (rst_rise)
      begin
        osc_q <= osc_strap;
        mode_q <= {debug_strap_pin_i, mode_select_mid_i, mode_select_low_i};
      end
    end
  end

  // counts the cycles the serial output is held low after release
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      so_cnt_q <= 2'(rspf_pkg::so_hold_cycles);
    end
    else
    begin
      if (in_reset)
        so_cnt_q <= 2'(rspf_pkg::so_hold_cycles);
      else if (so_cnt_q != 2'h0)
        so_cnt_q <= so_cnt_q - 2'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      debug_so_o <= 1'b0;
    end
    else
    begin
      debug_so_o <= (in_reset || so_cnt_q != 2'h0) ? 1'b0 : debug_sdo_i;
    end
  end

  // open-drain style: the pin is only ever pulled low, never driven high
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reset_pin_n_o <= 1'b0;
      reset_pin_oe_o <= 1'b0;
    end
    else
    begin
      reset_pin_n_o <= 1'b0;
      reset_pin_oe_o <= int_reset_req_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_select_mid_pd_en_o <= 1'b1;
    end
    else
    begin
      mode_select_mid_pd_en_o <= in_reset;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_colpitts_o <= rspf_pkg::rst_osc_type;
      osc_pierce_o <= ~rspf_pkg::rst_osc_type;
    end
    else
    begin
      osc_colpitts_o <= osc_q;
      osc_pierce_o <= ~osc_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_o <= rspf_pkg::rst_mode;
    end
    else
    begin
      mode_o <= mode_q;
    end
  end

  // pin pull-down keeps this low unless driven, giving single-wire
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      debug_spi_mode_o <= 1'b0;
      debug_serial_clock_o <= 1'b0;
    end
    else
    begin
      debug_spi_mode_o <= debug_link_select_i;
      debug_serial_clock_o <= debug_link_select_i;
    end
  end

  // the bus clock is sampled, so its edges are seen one system cycle late
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_clock_out_prev_q <= 1'b0;
    end
    else
    begin
      bus_clock_out_prev_q <= bus_clock_out_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tag_high_o <= 1'b0;
    end
    else
    begin
      if (bus_clock_out_fall)
        tag_high_o <= expanded & tag_enable_i & ~tag_high_input_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      free_cycle_indicator_o <= 1'b0;
    end
    else
    begin
      free_cycle_indicator_o <= expanded & free_cycle_en_i & cpu_bus_idle_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_a_o <= port_w'(rspf_pkg::rst_port);
    end
    else
    begin
      port_a_o <= a_val;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_b_o <= port_w'(rspf_pkg::rst_port);
    end
    else
    begin
      port_b_o <= b_val;
    end
  end

  // pads start as inputs so nothing fights the board before the mode is known
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_a_oe_o <= port_w'(rspf_pkg::rst_port);
    end
    else
    begin
      port_a_oe_o <= a_oe;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_b_oe_o <= port_w'(rspf_pkg::rst_port);
    end
    else
    begin
      port_b_oe_o <= b_oe;
    end
  end
endmodule : rspf_top
`default_nettype wire

//--- rspf_board.sv
`timescale 1ns/10ps
`default_nettype none
module rspf_board (
  // strap choice, bit 4 leaves the osc strap floating
  input wire logic [4:0] set_i,
  // strap pins
  output logic osc_o,
  output logic float_o,
  output logic [2:0] mode_o
);
  assign osc_o = set_i[3] | set_i[4];
  assign float_o = set_i[4];
  assign mode_o = set_i[2:0];
endmodule : rspf_board
`default_nettype wire

//--- rspf_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rspf_assertions (
  // watched ports
  input wire logic mclk_i, rst_i, reset_pin_n_i, int_reset_req_i, reset_pin_oe_o,
  osc_type_strap_i, debug_strap_pin_i, mode_select_mid_i, mode_select_low_i, osc_colpitts_o,
  mode_select_mid_pd_en_o, debug_link_select_i, debug_spi_mode_o, debug_so_o,
  free_cycle_en_i, cpu_bus_idle_i, free_cycle_indicator_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire quiet = reset_pin_n_i & ~int_reset_req_i;
  wire [2:0] pins = {debug_strap_pin_i, mode_select_mid_i, mode_select_low_i};
  property p_so; $rose(reset_pin_n_i) |-> !debug_so_o [*2]; endproperty
  a_so: assert property (p_so) else $error("so");
  property p_cap; $rose(reset_pin_n_i) |-> ##3 mode_o == $past(pins, 3); endproperty
  a_cap: assert property (p_cap) else $error("mode");
  property p_osc; $rose(reset_pin_n_i) |-> ##3 osc_colpitts_o == $past(osc_type_strap_i, 3); endproperty
  a_osc: assert property (p_osc) else $error("osc");
  property p_hold; quiet [*4] |-> $stable(mode_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_pd; 1 |=> mode_select_mid_pd_en_o == $past(~quiet); endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_spi; 1 |=> debug_spi_mode_o == $past(debug_link_select_i); endproperty
  a_spi: assert property (p_spi) else $error("spi");
  property p_oe; int_reset_req_i |=> reset_pin_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_free; quiet && free_cycle_en_i && cpu_bus_idle_i && mode_o[0] |=> free_cycle_indicator_o;
  endproperty
  a_free: assert property (p_free) else $error("free");
  c_rel: cover property ($rose(reset_pin_n_i));
  c_spi: cover property (debug_spi_mode_o);
  c_free: cover property (free_cycle_indicator_o);
endmodule : rspf_assertions
bind rspf_top rspf_assertions chk (.*);
`default_nettype wire

//--- rspf_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  bit mclk_i, reset_pin_n_i, int_reset_req_i, debug_link_select_i, bus_clock_out_i, tag_enable_i;
  bit free_cycle_en_i, cpu_bus_idle_i, addr_phase_i, narrow_hi_phase_i, bus_write_i;
  bit rst_i = 1'h1, debug_sdo_i = 1'h1, tag_high_input_i = 1'h1;
  bit [7:0] addr_hi_i = 8'h3c, addr_lo_i = 8'h5a, data_hi_i = 8'h96, data_lo_i = 8'ha5;
  bit [7:0] gpio_a_i = 8'hc3, gpio_b_i, gpio_a_oe_i, gpio_b_oe_i;
  bit [4:0] set;
  bit [4:0] tbl [4] = '{5'h0f, 5'h13, 5'h06, 5'h00};
  logic osc_type_strap_i, osc_type_strap_float_i, debug_strap_pin_i, mode_select_mid_i;
  logic mode_select_low_i, reset_pin_n_o, reset_pin_oe_o, mode_select_mid_pd_en_o, osc_pierce_o;
  logic osc_colpitts_o, debug_spi_mode_o, debug_serial_clock_o, debug_so_o, tag_high_o;
  logic free_cycle_indicator_o;
  logic [2:0] mode_o;
  logic [7:0] port_a_o, port_b_o, port_a_oe_o, port_b_oe_o;
  int failures, n_checks;
  always #20 mclk_i = ~mclk_i;
  rspf_board brd (.set_i(set), .osc_o(osc_type_strap_i), .float_o(osc_type_strap_float_i),
    .mode_o({debug_strap_pin_i, mode_select_mid_i, mode_select_low_i}));
  rspf_top uut (.*);
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic settle(int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic strap(logic [4:0] s);
    @(posedge mclk_i) reset_pin_n_i <= 1'h0;
    set <= s;
    settle(2);
    chk("pd", mode_select_mid_pd_en_o, 1);
    @(posedge mclk_i) reset_pin_n_i <= 1'h1;
    settle(1);
    chk("so", debug_so_o, 0);
    settle(2);
    chk("mode", mode_o, s[2:0]);
    chk("osc", {osc_colpitts_o, osc_pierce_o}, {s[3] | s[4], ~(s[3] | s[4])});
    chk("so_out", debug_so_o, 1);
    @(posedge mclk_i) set <= ~s;
    settle(2);
    chk("held", mode_o, s[2:0]);
  endtask : strap
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'h0;
    foreach (tbl[i]) strap(tbl[i]);
    chk("gpio", port_a_o, 8'hc3);
    chk("gpio_oe", {port_a_oe_o, port_b_oe_o}, 16'h0000);
    $display("straps done");
    strap(5'h05);
    @(posedge mclk_i) addr_phase_i <= 1'h1;
    settle(1);
    chk("addr", {port_a_o, port_b_o}, 16'h3c5a);
    chk("addr_oe", {port_a_oe_o, port_b_oe_o}, 16'hffff);
    @(posedge mclk_i) addr_phase_i <= 1'h0;
    bus_write_i <= 1'h1;
    settle(1);
    chk("lo", port_a_o, 8'ha5);
    chk("data_oe", {port_a_oe_o, port_b_oe_o}, 16'hff00);
    @(posedge mclk_i) narrow_hi_phase_i <= 1'h1;
    settle(1);
    chk("hi", port_a_o, 8'h96);
    $display("ports done");
    @(posedge mclk_i) debug_link_select_i <= 1'h1;
    {free_cycle_en_i, cpu_bus_idle_i, tag_enable_i, bus_clock_out_i} <= 4'hf;
    tag_high_input_i <= 1'h0;
    @(posedge mclk_i) bus_clock_out_i <= 1'h0;
    settle(2);
    chk("spi", {debug_spi_mode_o, debug_serial_clock_o, debug_so_o}, 3'h7);
    chk("free", free_cycle_indicator_o, 1);
    chk("tag", tag_high_o, 1);
    @(posedge mclk_i) int_reset_req_i <= 1'h1;
    settle(1);
    chk("rst", {reset_pin_oe_o, reset_pin_n_o}, 2'h2);
    $display("debug and bus done");
    give_verdict();
  end
  initial
  begin
    // the tests need about 70 cycles, so this leaves a wide margin
    #40us;
    failures++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
